/* File: rtl/txcb_device.sv */
// Device end of the transmit system bus: captures address and data on the
// link clock and hands each event taken while no handshake is busy to the clk_sys domain by a toggle handshake.
// Assumes the link end launches on the falling link clock edge.
//
// Functional notes
// - All bus signals timed by transmit system clock.
// - Link clock at most 66/52 MHz.
// - Address selects data port and polled port.
// - Packet level 3: address only polls status.
// - Address sampled on rising edge, bit 4 MSB.
// - 32-bit data bus captured on rising edge.
// - 32-bit width: bit 31 MSB.
// - 16-bit width: bits 15:0, upper ignored.
// - 8-bit width: bits 7:0, upper ignored.
`timescale 1ns/1ps
module txcb_device (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   txcb_if.device bus,
   input wire txcb_pkg::txcb_mode_type mode_i,
   input wire txcb_pkg::txcb_width_type width_i,
   output logic word_valid_o,
   output logic [txcb_pkg::DATA_W-1:0] word_data_o,
   output logic [txcb_pkg::ADDR_W-1:0] word_port_o,
   output logic [txcb_pkg::ADDR_W-1:0] poll_port_o,
   output logic overrun_o
);

   ////////////////////////////////////////////////////////////////////////////
   // Link domain

   txcb_pkg::txcb_mode_type mode_s1_r, mode_s2_r;
   txcb_pkg::txcb_width_type width_s1_r, width_s2_r;
   logic ack_s1_r, ack_s2_r;
   // Acknowledge flop runs on clk_sys; declared here because the link sync reads it
   logic ack_r;
   logic req_tgl_r;
   logic [txcb_pkg::ADDR_W-1:0] sel_port_r;
   logic drop_r;
   logic hold_word_r;
   logic hold_drop_r;
   logic [txcb_pkg::DATA_W-1:0] hold_data_r;
   logic [txcb_pkg::ADDR_W-1:0] hold_port_r;
   logic [txcb_pkg::ADDR_W-1:0] hold_poll_r;

   wire pkt_l3 = (mode_s2_r == txcb_pkg::TXCB_PKT_L3);
   wire busy = req_tgl_r ^ ack_s2_r;
   // Address bits kept in bus order, [4] most significant
   wire [txcb_pkg::ADDR_W-1:0] addr_in = bus.tx_port_address;
   wire [txcb_pkg::DATA_W-1:0] data_in =
      txcb_pkg::lane_mask(bus.tx_data, width_s2_r);
   // Level 3 packet mode takes the data port from the select word
   wire [txcb_pkg::ADDR_W-1:0] data_port = pkt_l3 ? sel_port_r : addr_in;
   wire new_poll = addr_in != hold_poll_r;
   wire launch = ~busy & (bus.tx_data_valid | new_poll);

   // Configuration is quasi-static; two flops keep the link side clean
   always_ff @(posedge bus.tx_system_clock or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mode_s1_r <= txcb_pkg::MODE_RST;
         mode_s2_r <= txcb_pkg::MODE_RST;
         width_s1_r <= txcb_pkg::WIDTH_RST;
         width_s2_r <= txcb_pkg::WIDTH_RST;
         ack_s1_r <= 1'b0;
         ack_s2_r <= 1'b0;
      end else begin
         mode_s1_r <= mode_i;
         mode_s2_r <= mode_s1_r;
         width_s1_r <= width_i;
         width_s2_r <= width_s1_r;
         ack_s1_r <= ack_r;
         ack_s2_r <= ack_s1_r;
      end
   end

   // Port chosen by an in-band select cycle
   always_ff @(posedge bus.tx_system_clock or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sel_port_r <= txcb_pkg::ADDR_RST;
      end else if (bus.tx_port_select && pkt_l3) begin
         sel_port_r <= bus.tx_data[txcb_pkg::ADDR_W-1:0];
      end
   end

   // Capture on the rising link edge; hold stays stable until acknowledged
   always_ff @(posedge bus.tx_system_clock or negedge rst_n_i) begin
      if (!rst_n_i) begin
         req_tgl_r <= 1'b0;
         drop_r <= 1'b0;
         hold_word_r <= 1'b0;
         hold_drop_r <= 1'b0;
         hold_data_r <= txcb_pkg::DATA_RST;
         hold_port_r <= txcb_pkg::ADDR_RST;
         hold_poll_r <= txcb_pkg::ADDR_RST;
      end else if (launch) begin
         req_tgl_r <= ~req_tgl_r;
         hold_word_r <= bus.tx_data_valid;
         // Loss is reported only beside a word, so a poll event keeps it pending
         hold_drop_r <= drop_r & bus.tx_data_valid;
         hold_poll_r <= addr_in;
         if (bus.tx_data_valid) begin
            drop_r <= 1'b0;
            hold_data_r <= data_in;
            hold_port_r <= data_port;
         end
      end else if (busy && bus.tx_data_valid) begin
         // No buffer: a word arriving mid-handshake is lost and reported
         drop_r <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // System domain

   logic req_s1_r, req_s2_r;

   wire req_edge = req_s2_r ^ ack_r;

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         req_s1_r <= 1'b0;
         req_s2_r <= 1'b0;
         ack_r <= 1'b0;
      end else begin
         req_s1_r <= req_tgl_r;
         req_s2_r <= req_s1_r;
         ack_r <= req_s2_r;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         word_valid_o <= 1'b0;
         overrun_o <= 1'b0;
         word_data_o <= txcb_pkg::DATA_RST;
         word_port_o <= txcb_pkg::ADDR_RST;
         poll_port_o <= txcb_pkg::ADDR_RST;
      end else begin
         word_valid_o <= req_edge & hold_word_r;
         overrun_o <= req_edge & hold_drop_r;
         if (req_edge) begin
            poll_port_o <= hold_poll_r;
            if (hold_word_r) begin
               word_data_o <= hold_data_r;
               word_port_o <= hold_port_r;
            end
         end
      end
   end

endmodule

/* File: rtl/txcb_if.sv */
// Transmit system bus between the link-layer end and the device end.
// Assumes the link end drives every signal; the device end only samples.
`timescale 1ns/1ps
interface txcb_if;
   logic tx_system_clock;
   logic [txcb_pkg::ADDR_W-1:0] tx_port_address;
   logic [txcb_pkg::DATA_W-1:0] tx_data;
   logic tx_data_valid;
   logic tx_port_select;

   modport link (
      output tx_system_clock,
      output tx_port_address,
      output tx_data,
      output tx_data_valid,
      output tx_port_select
   );

   modport device (
      input tx_system_clock,
      input tx_port_address,
      input tx_data,
      input tx_data_valid,
      input tx_port_select
   );
endinterface

/* File: rtl/txcb_link.sv */
// Link-layer end: makes the transmit system clock by dividing clk_sys and
// drives address and data, launching on the falling link clock edge.
// Assumes the user side keeps send_* stable while send_valid_i waits.
`timescale 1ns/1ps
module txcb_link (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   txcb_if.link bus,
   input wire txcb_pkg::txcb_mode_type mode_i,
   input wire txcb_pkg::txcb_width_type width_i,
   input wire logic send_valid_i,
   input wire logic [txcb_pkg::DATA_W-1:0] send_data_i,
   input wire logic [txcb_pkg::ADDR_W-1:0] send_port_i,
   input wire logic [txcb_pkg::ADDR_W-1:0] poll_port_i,
   output logic send_ready_o
);

   ////////////////////////////////////////////////////////////////////////////

   logic clk_r;
   logic valid_r, sel_r, pend_r;
   logic [txcb_pkg::ADDR_W-1:0] addr_r, cur_port_r;
   logic [txcb_pkg::DATA_W-1:0] data_r, hold_r;

   wire pkt_l3 = (mode_i == txcb_pkg::TXCB_PKT_L3);
   wire take = send_valid_i & send_ready_o;
   // Level 3 packet mode names the port in-band, not on the address
   wire need_sel = pkt_l3 & (send_port_i != cur_port_r);
   wire [txcb_pkg::DATA_W-1:0] word = txcb_pkg::lane_mask(send_data_i, width_i);

   assign bus.tx_system_clock = clk_r;
   assign bus.tx_port_address = addr_r;
   assign bus.tx_data = data_r;
   assign bus.tx_data_valid = valid_r;
   assign bus.tx_port_select = sel_r;

   // Clock from divider; 25 MHz keeps under both level ceilings
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         clk_r <= 1'b0;
         send_ready_o <= 1'b0;
      end else begin
         clk_r <= ~clk_r;
         send_ready_o <= ~clk_r & ~pend_r;
      end
   end

   // Launch at the falling link edge so the device samples mid-period
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         valid_r <= 1'b0;
         sel_r <= 1'b0;
         pend_r <= 1'b0;
         addr_r <= txcb_pkg::ADDR_RST;
         cur_port_r <= txcb_pkg::ADDR_RST;
         data_r <= txcb_pkg::DATA_RST;
         hold_r <= txcb_pkg::DATA_RST;
      end else if (clk_r) begin
         valid_r <= 1'b0;
         sel_r <= 1'b0;
         addr_r <= poll_port_i;
         if (pend_r) begin
            pend_r <= 1'b0;
            valid_r <= 1'b1;
            data_r <= hold_r;
         end else if (take && need_sel) begin
            sel_r <= 1'b1;
            data_r <= {{(txcb_pkg::DATA_W - txcb_pkg::ADDR_W){1'b0}}, send_port_i};
            cur_port_r <= send_port_i;
            hold_r <= word;
            pend_r <= 1'b1;
         end else if (take) begin
            valid_r <= 1'b1;
            data_r <= word;
            if (!pkt_l3) begin
               addr_r <= send_port_i;
            end
         end
      end
   end

endmodule

/* File: rtl/txcb_pkg.sv */
// Shared constants, modes and lane helper for the transmit cell bus stage.
// Assumes both ends and the interface compile after this package.
package txcb_pkg;
   localparam int unsigned ADDR_W = 5;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned SYS_CLK_HZ = 50_000_000;
   // Link clock ceilings per bus level
   localparam int unsigned LINK_MAX_L3_MHZ = 66;
   localparam int unsigned LINK_MAX_L2_MHZ = 52;
   // Link clock made by halving clk_sys: 25 MHz, under both ceilings
   localparam int unsigned LINK_DIV = 2;
   localparam int unsigned LINK_CLK_HZ = SYS_CLK_HZ / LINK_DIV;
   localparam logic [ADDR_W-1:0] ADDR_RST = 5'h00;
   localparam logic [DATA_W-1:0] DATA_RST = 32'h0000_0000;

   typedef enum logic [1:0] {
      TXCB_CELL_L2,
      TXCB_CELL_L3,
      TXCB_PKT_L2,
      TXCB_PKT_L3
   } txcb_mode_type;

   typedef enum logic [1:0] {
      TXCB_W8,
      TXCB_W16,
      TXCB_W32
   } txcb_width_type;

   localparam txcb_mode_type MODE_RST = TXCB_CELL_L2;
   localparam txcb_width_type WIDTH_RST = TXCB_W32;

   // Keep only the lanes the configured width uses
   function automatic logic [DATA_W-1:0] lane_mask(input logic [DATA_W-1:0] d,
                                                   input txcb_width_type w);
      logic [DATA_W-1:0] r;
      r = d;
      if (w == TXCB_W16) begin
         r = {16'h0000, d[15:0]};
      end else if (w == TXCB_W8) begin
         r = {24'h00_0000, d[7:0]};
      end
      return r;
   endfunction
endpackage

/* File: tb/tb.sv */
// Bench: link end feeds device end over the bus; queues model delivery.
// Assumes the rtl package, interface and both ends compile first.
`timescale 1ns/1ps
module tb;
   logic clk_sys_i = 0, rst_n_i = 0, send_valid_i = 0;
   logic send_ready_o, word_valid_o, overrun_o;
   logic [31:0] send_data_i = 0, word_data_o, seed = 32'hd402baa6;
   logic [4:0] send_port_i = 0, poll_port_i = 0, word_port_o, poll_port_o;
   txcb_pkg::txcb_mode_type mode_i = txcb_pkg::TXCB_CELL_L2;
   txcb_pkg::txcb_width_type width_i = txcb_pkg::TXCB_W32;
   int failures = 0, num_checks = 0, cyc = 0;
   logic [31:0] dq[$], pq[$], oq[$];
   always #10 clk_sys_i = ~clk_sys_i;
   txcb_if bus();
   txcb_link i_txcb_link(.clk_sys_i, .rst_n_i, .bus(bus.link), .mode_i, .width_i,
      .send_valid_i, .send_data_i, .send_port_i, .poll_port_i, .send_ready_o);
   txcb_device i_txcb_device(.clk_sys_i, .rst_n_i, .bus(bus.device), .mode_i, .width_i,
      .word_valid_o, .word_data_o, .word_port_o, .poll_port_o, .overrun_o);
   txcb_properties i_txcb_properties(.clk_sys_i, .rst_n_i,
      .tx_system_clock(bus.tx_system_clock), .tx_port_address(bus.tx_port_address),
      .tx_data(bus.tx_data), .tx_data_valid(bus.tx_data_valid),
      .tx_port_select(bus.tx_port_select), .mode_i, .width_i);
   ////////////////////////////////////////////////////////////////////////
   function logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         failures++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask
   task give_verdict();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // Words spaced by gap; gap 0 keeps valid up for a back-to-back word
   task send(input logic [31:0] d, input logic [4:0] p, input bit keep, ov, input int gap);
      int n;
      n = 0;
      send_valid_i <= 1;
      send_data_i <= d;
      send_port_i <= p;
      do begin
         @(posedge clk_sys_i);
         n++;
      end while (send_ready_o !== 1'b1 && n < 50);
      chk("ready", 1, n < 50);
      if (keep) begin
         dq.push_back(width_i == txcb_pkg::TXCB_W8 ? d & 32'hff :
                      width_i == txcb_pkg::TXCB_W16 ? d & 32'hffff : d);
         pq.push_back(p);
         oq.push_back(ov);
      end
      if (gap > 0) begin
         send_valid_i <= 0;
         repeat (gap) @(posedge clk_sys_i);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   always @(posedge clk_sys_i) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         failures++;
         give_verdict();
      end
      if (word_valid_o === 1'b1) begin
         chk("count", 1, dq.size() > 0);
         if (dq.size() > 0) begin
            chk("data", dq.pop_front(), word_data_o);
            chk("port", pq.pop_front(), word_port_o);
            chk("overrun", oq.pop_front(), overrun_o);
         end
      end
   end
   initial begin
      logic [31:0] r;
      repeat (20) @(posedge clk_sys_i);
      rst_n_i <= 1;
      for (int k = 0; k < 12; k++) begin
         mode_i <= txcb_pkg::txcb_mode_type'(2'(k / 3));
         width_i <= txcb_pkg::txcb_width_type'(2'(k % 3));
         repeat (8) @(posedge clk_sys_i);
         repeat (3) send(rnd(), rnd() & 32'h1f, 1, 0, 24);
         r = rnd();
         poll_port_i <= r[4:0];
         repeat (40) @(posedge clk_sys_i);
         chk("poll", r[4:0], poll_port_o);
      end
      // Second word lands while the handshake is busy and is lost
      send(32'ha5a5_0001, 5'h07, 1, 0, 0);
      send(32'ha5a5_0002, 5'h07, 0, 0, 24);
      send(32'ha5a5_0003, 5'h07, 1, 1, 24);
      rst_n_i <= 0;
      dq.delete();
      pq.delete();
      oq.delete();
      repeat (4) @(posedge clk_sys_i);
      chk("rst_data", 0, word_data_o);
      chk("rst_poll", 0, poll_port_o);
      rst_n_i <= 1;
      // Config sync restarts at its reset mode and a start-up poll runs first
      repeat (20) @(posedge clk_sys_i);
      send(32'h1234_5678, 5'h1f, 1, 0, 24);
      chk("pending", 0, dq.size());
      give_verdict();
   end
endmodule

/* File: tb/txcb_properties.sv */
// Checker on the transmit system bus, all sampled on clk_sys.
// Assumes tb instantiates it beside the bus with the config levels.
`timescale 1ns/1ps
module txcb_properties (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic tx_system_clock,
   input wire logic [txcb_pkg::ADDR_W-1:0] tx_port_address,
   input wire logic [txcb_pkg::DATA_W-1:0] tx_data,
   input wire logic tx_data_valid,
   input wire logic tx_port_select,
   input wire txcb_pkg::txcb_mode_type mode_i,
   input wire txcb_pkg::txcb_width_type width_i
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);
   ////////////////////////////////////////////////////////////////////////
   a_clk_divides: assert property (
      $past(rst_n_i, 2) |-> tx_system_clock != $past(tx_system_clock))
      else $error("link clock not half of clk_sys");
   // Changes only while link clock low, so rising edge sees settled bus
   a_data_settled: assert property (
      !$stable(tx_data) |-> !tx_system_clock) else $error("data moved at rise");
   a_addr_settled: assert property (
      !$stable(tx_port_address) |-> !tx_system_clock) else $error("addr moved at rise");
   a_ctrl_settled: assert property (
      !$stable({tx_data_valid, tx_port_select}) |-> !tx_system_clock)
      else $error("strobe moved at rise");
   a_w16_lanes: assert property (
      tx_data_valid && width_i == txcb_pkg::TXCB_W16 |-> tx_data[31:16] == 16'h0000)
      else $error("upper lanes set in 16-bit");
   a_w8_lanes: assert property (
      tx_data_valid && width_i == txcb_pkg::TXCB_W8 |-> tx_data[31:8] == 24'h00_0000)
      else $error("upper lanes set in 8-bit");
   a_select_pkt_l3: assert property (
      tx_port_select |-> mode_i == txcb_pkg::TXCB_PKT_L3) else $error("select outside mode");
   a_valid_stands: assert property (
      $rose(tx_data_valid) |-> tx_data_valid [*2]) else $error("valid too short");
   a_select_once: assert property (
      $rose(tx_port_select) |-> tx_port_select [*2] ##1 !tx_port_select)
      else $error("select not one period");
   c_w8_word: cover property (tx_data_valid && width_i == txcb_pkg::TXCB_W8);
   c_w16_word: cover property (tx_data_valid && width_i == txcb_pkg::TXCB_W16);
   c_select: cover property ($rose(tx_port_select));
endmodule
